// *** dv/nvmba_properties.sv ***
// Port checks for the byte access block
`timescale 1ns/1ps
module nvmba_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic global_irq_enable,
    input wire logic stack_free,
    input wire logic irq_serviced,
    input wire logic irq_vector_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Address decode helpers
    wire logic mapped = reg_addr inside {8'h00, 8'h01, 8'h40, 8'h41};
    wire logic irq_wr = reg_wr && reg_addr == 8'h41;
    // Read data only in the cycle after a read
    a_idle_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_ctl_upper_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h40
        |-> reg_rdata[7:4] == 4'h0) else $error("control upper bits set");
    a_index_upper_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00
        |-> reg_rdata[7:6] == 2'h0) else $error("index upper bits set");
    a_irq_upper_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h41
        |-> reg_rdata[7:2] == 6'h00) else $error("irq upper bits set");
    a_unmapped_reads_zero: assert property ($past(reg_rd) && !$past(mapped)
        |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
    // Vector request and its causes
    a_vector_needs_enables: assert property (irq_vector_req |-> $past(global_irq_enable)
        && $past(stack_free) && !$past(irq_serviced)) else $error("vector without enables");
    a_service_drops_vector: assert property (irq_serviced |=> !irq_vector_req [*2])
        else $error("vector survives service");
    a_vector_holds: assert property (irq_vector_req && global_irq_enable && stack_free
        && !irq_serviced && !$past(irq_wr) |=> irq_vector_req) else $error("vector dropped");
    // Main scenarios
    cover property ($rose(irq_vector_req));
    cover property (irq_serviced && irq_vector_req);
    cover property (reg_rd && reg_addr == 8'h40);
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the byte access block
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic gie = 1'b0;
    logic sfree = 1'b0;
    logic srv = 1'b0;
    logic slp = 1'b0;
    logic [7:0] rdata;
    logic irq;
    int n_fail = 0;
    int check_count = 0;
    // Clock and device
    always #10 clk = ~clk;
    nvmba_top #(.WRITE_TICKS(3)) dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .global_irq_enable(gie), .stack_free(sfree), .irq_serviced(srv),
        .sleep_entry(slp), .irq_vector_req(irq));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Register bus cycles
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic r(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string n);
        logic [7:0] v;
        r(a, v);
        chk(n, exp, v);
    endtask
    task automatic vchk(input logic exp);
        repeat (2) @(posedge clk);
        #1;
        chk("vector", {7'h00, exp}, {7'h00, irq});
    endtask
    // Poll a go bit until the device clears it
    task automatic wait_clr(input int b);
        logic [7:0] v;
        int i;
        for (i = 0; i < 400; i++) begin
            r(8'h40, v);
            if (v[b] === 1'b0) break;
        end
        if (i == 400) begin
            n_fail++;
            $display("Error go_bit expected 0 seen 1");
            finish_test();
        end
    endtask
    task automatic start_write(input logic [7:0] i, input logic [7:0] d);
        gie <= 1'b0;
        w(8'h00, i);
        w(8'h01, d);
        w(8'h40, 8'h08);
        w(8'h40, 8'h0C);
    endtask
    task automatic do_read(input logic [7:0] i, input logic [7:0] exp, input string n);
        w(8'h00, i);
        w(8'h01, ~exp);
        w(8'h40, 8'h02);
        w(8'h40, 8'h03);
        wait_clr(0);
        rc(8'h01, exp, n);
        w(8'h40, 8'h00);
    endtask
    // Scenarios
    task automatic t_reset;
        rc(8'h40, 8'h00, "control");
        rc(8'h00, 8'h00, "index");
        rc(8'h01, 8'h00, "value");
        rc(8'h41, 8'h00, "irq");
        rc(8'h02, 8'h00, "unmapped");
    endtask
    task automatic t_refuse;
        w(8'h40, 8'h04);
        rc(8'h40, 8'h00, "go_no_permit");
        w(8'h40, 8'h01);
        rc(8'h40, 8'h00, "fetch_no_permit");
        w(8'h40, 8'h0C);
        rc(8'h40, 8'h08, "go_same_write");
        w(8'h40, 8'h00);
    endtask
    task automatic t_write_irq;
        sfree <= 1'b1;
        w(8'h41, 8'h01);
        start_write(8'h3F, 8'hA5);
        gie <= 1'b1;
        rc(8'h40, 8'h0C, "write_busy");
        w(8'h00, 8'h11);
        rc(8'h00, 8'h3F, "index_locked");
        w(8'h01, 8'h22);
        rc(8'h01, 8'hA5, "value_locked");
        wait_clr(2);
        rc(8'h41, 8'h03, "flag_write_end");
        vchk(1'b1);
        gie <= 1'b0;
        vchk(1'b0);
        gie <= 1'b1;
        sfree <= 1'b0;
        vchk(1'b0);
        sfree <= 1'b1;
        vchk(1'b1);
        srv <= 1'b1;
        @(posedge clk);
        srv <= 1'b0;
        vchk(1'b0);
        rc(8'h41, 8'h01, "flag_serviced");
        w(8'h40, 8'h00);
    endtask
    task automatic t_read;
        do_read(8'h3F, 8'hA5, "read_back");
        rc(8'h00, 8'h3F, "no_increment");
        // Both go bits in one write: the fetch wins, no write starts
        w(8'h40, 8'h0A);
        w(8'h40, 8'h0F);
        wait_clr(0);
        rc(8'h40, 8'h0A, "fetch_wins");
        w(8'h40, 8'h00);
        rc(8'h41, 8'h01, "no_flag_on_read");
    endtask
    task automatic t_write_quiet;
        w(8'h41, 8'h00);
        start_write(8'h00, 8'h5A);
        gie <= 1'b1;
        wait_clr(2);
        rc(8'h41, 8'h02, "flag_disabled");
        vchk(1'b0);
        w(8'h41, 8'h00);
        rc(8'h41, 8'h00, "flag_sw_clear");
        w(8'h40, 8'h00);
        do_read(8'h00, 8'h5A, "read_index0");
    endtask
    task automatic t_sleep;
        logic [7:0] v;
        start_write(8'h01, 8'h77);
        slp <= 1'b1;
        repeat (3) @(posedge clk);
        slp <= 1'b0;
        r(8'h40, v);
        chk("sleep_abort", 8'h00, v & 8'h05);
        rc(8'h41, 8'h00, "sleep_no_flag");
        rc(8'h01, 8'h77, "sleep_value");
        w(8'h40, 8'h00);
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_refuse();
        t_write_irq();
        t_read();
        t_write_quiet();
        t_sleep();
        finish_test();
    end
endmodule
bind nvmba_top nvmba_properties u_props (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .global_irq_enable(global_irq_enable), .stack_free(stack_free),
    .irq_serviced(irq_serviced), .irq_vector_req(irq_vector_req));

// *** hdl/nvmba_cfg.svh ***
// Register map, field positions, reset values and timing for the byte access block
`ifndef NVMBA_CFG_SVH
`define NVMBA_CFG_SVH

// Register offsets on the plain register port
`define NVMBA_ADDR_W 8
`define NVMBA_OFS_INDEX 8'h00
`define NVMBA_OFS_VALUE 8'h01
`define NVMBA_OFS_CONTROL 8'h40
`define NVMBA_OFS_IRQ 8'h41

// Array shape
`define NVMBA_DATA_W 8
`define NVMBA_INDEX_W 6

// Control register field positions
`define NVMBA_CTL_FETCH_GO 0
`define NVMBA_CTL_FETCH_PERMIT 1
`define NVMBA_CTL_PROGRAM_GO 2
`define NVMBA_CTL_PROGRAM_PERMIT 3

// Interrupt register field positions
`define NVMBA_IRQ_ENABLE 0
`define NVMBA_IRQ_FLAG 1

// Reset values
`define NVMBA_RST_INDEX 6'h00
`define NVMBA_RST_VALUE 8'h00
`define NVMBA_RST_BYTE 8'h00

// Timing: system clock period, write timer tick and write time
`define NVMBA_CLK_NS 20
`define NVMBA_TICK_NS 1000
`define NVMBA_WRITE_TIME_US 2000
`define NVMBA_TICK_W 6
`define NVMBA_WCNT_W 16

`endif

// *** hdl/nvmba_mem.sv ***
// Sixty-four by eight storage array with registered read data
`timescale 1ns/1ps
`include "nvmba_cfg.svh"

module nvmba_mem
    import nvmba_pkg::*;
(
    input wire logic clk,
    input wire logic write_en,
    input wire logic [`NVMBA_INDEX_W-1:0] write_index,
    input wire logic [`NVMBA_DATA_W-1:0] write_byte,
    input wire logic read_en,
    input wire logic [`NVMBA_INDEX_W-1:0] read_index,
    output logic [`NVMBA_DATA_W-1:0] read_byte
);

    logic [`NVMBA_DATA_W-1:0] cells [0:(1<<`NVMBA_INDEX_W)-1];

    // Commit and fetch, read data from a register
    always_ff @(posedge clk) begin
        if (write_en) begin
            cells[write_index] <= write_byte;
        end
        if (read_en) begin
            read_byte <= cells[read_index];
        end
    end

endmodule

// *** hdl/nvmba_pkg.sv ***
// Types shared by the byte access block
package nvmba_pkg;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        nvmba_st_idle  = 4'b0001,
        nvmba_st_read  = 4'b0010,
        nvmba_st_rdone = 4'b0100,
        nvmba_st_write = 4'b1000
    } nvmba_state_t;

endpackage

// *** hdl/nvmba_top.sv ***
// Control logic for single-byte reads and writes of the nonvolatile data array
//
// Overview of operation
// (R01) Interrupt request raised when a byte write finishes, never after a read.
// (R02) Software sets nvm_irq_enable before expecting end-of-write interrupts.
// (R03) nvm_irq_flag set at every write end, enabled or not.
// (R04) Vector only with flag, both enables high and a free stack level.
// (R05) Flag cleared automatically when the interrupt is serviced.
// (R06) Software sets program_cycle_go right after setting program_permit.
// (R07) Software masks global interrupts around the start of a write.
// (R08) Entering idle or sleep during an operation aborts it; it fails.
// (R09) Software keeps program_permit low when not writing.
// (R10) Software keeps the pointer high bytes zero to hide the control register.
// (R11) Software may read the byte back to verify a write.
// (R12) Every read needs a fresh index and a fresh fetch_cycle_go; no increment.
// (R13) Software reaches nvm_control through pointer one and its indirect port.
// (R14) Read: load index, set fetch_permit, then fetch_cycle_go separately.
// (R15) fetch_cycle_go clears when data valid; nvm_byte_value then holds it.
// (R16) Write: load index and value, set program_permit, then program_cycle_go.
// (R17) program_cycle_go stays high until the byte is committed.
// (R18) Software clears nvm_control after its last read.
// (R19) Sixty-four eight-bit locations, selected by a six-bit index.
// (R20) program_cycle_go self-clears at write end; ignored without program_permit.
// (R21) fetch_cycle_go self-clears at read end; ignored without fetch_permit.
// (R22) program_permit is cleared by reset.
// (R23) Flag set in the same cycle program_cycle_go clears at write completion.
// (R24) Index and value writes ignored while a write is in progress.
`timescale 1ns/1ps
`include "nvmba_cfg.svh"

module nvmba_top
    import nvmba_pkg::*;
#(
    parameter int WRITE_TICKS = `NVMBA_WRITE_TIME_US
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`NVMBA_ADDR_W-1:0] reg_addr,
    input wire logic [`NVMBA_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`NVMBA_DATA_W-1:0] reg_rdata,
    input wire logic global_irq_enable,
    input wire logic stack_free,
    input wire logic irq_serviced,
    input wire logic sleep_entry,
    output logic irq_vector_req
);

    // Write timer tick length in system cycles, rounded up
    localparam int TICK_CYC = (`NVMBA_TICK_NS + `NVMBA_CLK_NS - 1) / `NVMBA_CLK_NS;
    localparam logic [`NVMBA_TICK_W-1:0] TICK_LAST = `NVMBA_TICK_W'(TICK_CYC - 1);
    localparam logic [`NVMBA_WCNT_W-1:0] WCNT_LAST = `NVMBA_WCNT_W'(WRITE_TICKS - 1);
    localparam logic [`NVMBA_TICK_W-1:0] TICK_ZERO = `NVMBA_TICK_W'(0);
    localparam logic [`NVMBA_WCNT_W-1:0] WCNT_ZERO = `NVMBA_WCNT_W'(0);

    // Software visible state
    logic [`NVMBA_INDEX_W-1:0] nvm_byte_index;
    logic [`NVMBA_DATA_W-1:0] nvm_byte_value;
    logic fetch_cycle_go;
    logic fetch_permit;
    logic program_cycle_go;
    logic program_permit;
    logic nvm_irq_enable;
    logic nvm_irq_flag;

    // Sequencer and write timer
    nvmba_state_t state;
    nvmba_state_t next_state;
    logic [`NVMBA_TICK_W-1:0] tick_cnt;
    logic [`NVMBA_WCNT_W-1:0] write_cnt;
    logic [`NVMBA_DATA_W-1:0] mem_q;

    // Address decode
    wire sel_index = (reg_addr == `NVMBA_OFS_INDEX);
    wire sel_value = (reg_addr == `NVMBA_OFS_VALUE);
    wire sel_control = (reg_addr == `NVMBA_OFS_CONTROL);
    wire sel_irq = (reg_addr == `NVMBA_OFS_IRQ);
    wire wr_index = reg_wr && sel_index;
    wire wr_value = reg_wr && sel_value;
    wire wr_control = reg_wr && sel_control;
    wire wr_irq = reg_wr && sel_irq;

    // State decode
    wire is_idle = (state == nvmba_st_idle);
    wire is_read = (state == nvmba_st_read);
    wire is_rdone = (state == nvmba_st_rdone);
    wire is_write = (state == nvmba_st_write);
    wire busy = !is_idle;

    // Start requests use the permits already held, not the ones in this write
    wire start_fetch = wr_control && reg_wdata[`NVMBA_CTL_FETCH_GO]
        && fetch_permit && is_idle; // R21 R14
    wire start_program = wr_control && reg_wdata[`NVMBA_CTL_PROGRAM_GO]
        && program_permit && is_idle && !start_fetch; // R20 R16

    // Write timer events
    wire tick = is_write && (tick_cnt == TICK_LAST);
    wire write_done = tick && (write_cnt == WCNT_LAST) && !sleep_entry;

    // Abort of any pending operation on power mode entry
    wire abort = busy && sleep_entry; // R08

    // Memory strobes
    wire mem_write = write_done; // R17
    wire mem_read = is_read && !sleep_entry;
    wire read_done = is_rdone && !sleep_entry;

    // Index and value accept software only when no write runs
    wire index_we = wr_index && !is_write; // R24
    wire value_we = wr_value && !is_write; // R24

    // Read data mux, reserved bits read zero
    wire [`NVMBA_DATA_W-1:0] control_view = {4'h0, program_permit, program_cycle_go,
        fetch_permit, fetch_cycle_go};
    wire [`NVMBA_DATA_W-1:0] irq_view = {6'h00, nvm_irq_flag, nvm_irq_enable};
    wire [`NVMBA_DATA_W-1:0] index_view = {2'h0, nvm_byte_index};
    wire [`NVMBA_DATA_W-1:0] read_mux =
        sel_index ? index_view :
        sel_value ? nvm_byte_value :
        sel_control ? control_view :
        sel_irq ? irq_view : `NVMBA_RST_BYTE;

    // Interrupt vector request condition
    wire vector_cond = nvm_irq_flag && nvm_irq_enable && global_irq_enable
        && stack_free; // R04

    // Storage array
    nvmba_mem u_mem (
        .clk(clk),
        .write_en(mem_write),
        .write_index(nvm_byte_index),
        .write_byte(nvm_byte_value),
        .read_en(mem_read),
        .read_index(nvm_byte_index),
        .read_byte(mem_q)
    ); // R19

    // Next state
    always_comb begin
        next_state = state;
        case (state)
            nvmba_st_idle: begin
                if (start_fetch) begin
                    next_state = nvmba_st_read;
                end else if (start_program) begin
                    next_state = nvmba_st_write;
                end
            end
            nvmba_st_read: begin
                next_state = nvmba_st_rdone;
            end
            nvmba_st_rdone: begin
                next_state = nvmba_st_idle;
            end
            nvmba_st_write: begin
                if (write_done) begin
                    next_state = nvmba_st_idle;
                end
            end
            default: begin
                next_state = nvmba_st_idle;
            end
        endcase
        if (abort) begin
            next_state = nvmba_st_idle; // R08
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= nvmba_st_idle;
        end else begin
            state <= next_state;
        end
    end

    // Tick divider, runs only during a write
    always_ff @(posedge clk) begin
        if (!rst_n || !is_write || tick) begin
            tick_cnt <= TICK_ZERO;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    // Write time counter in ticks
    always_ff @(posedge clk) begin
        if (!rst_n || !is_write) begin
            write_cnt <= WCNT_ZERO;
        end else if (tick) begin
            write_cnt <= write_cnt + 1'b1;
        end
    end

    // Byte index register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nvm_byte_index <= `NVMBA_RST_INDEX;
        end else if (index_we) begin
            nvm_byte_index <= reg_wdata[`NVMBA_INDEX_W-1:0];
        end
    end

    // Byte value register, loaded by software or by a finished read
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nvm_byte_value <= `NVMBA_RST_VALUE;
        end else if (read_done) begin
            nvm_byte_value <= mem_q; // R15
        end else if (value_we) begin
            nvm_byte_value <= reg_wdata;
        end
    end

    // Permit bits, plain software bits
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            program_permit <= 1'b0; // R22
            fetch_permit <= 1'b0;
        end else if (wr_control) begin
            program_permit <= reg_wdata[`NVMBA_CTL_PROGRAM_PERMIT];
            fetch_permit <= reg_wdata[`NVMBA_CTL_FETCH_PERMIT];
        end
    end

    // Fetch go bit, set by software, cleared by hardware
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fetch_cycle_go <= 1'b0;
        end else if (start_fetch) begin
            fetch_cycle_go <= 1'b1;
        end else if (read_done || abort) begin
            fetch_cycle_go <= 1'b0; // R21 R15
        end
    end

    // Program go bit, held until the commit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            program_cycle_go <= 1'b0;
        end else if (start_program) begin
            program_cycle_go <= 1'b1;
        end else if (write_done || abort) begin
            program_cycle_go <= 1'b0; // R20 R17
        end
    end

    // Interrupt enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nvm_irq_enable <= 1'b0;
        end else if (wr_irq) begin
            nvm_irq_enable <= reg_wdata[`NVMBA_IRQ_ENABLE];
        end
    end

    // Request flag, set by write end only, set beats any clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nvm_irq_flag <= 1'b0;
        end else if (write_done) begin
            nvm_irq_flag <= 1'b1; // R01 R03 R23
        end else if (irq_serviced) begin
            nvm_irq_flag <= 1'b0; // R05
        end else if (wr_irq && !reg_wdata[`NVMBA_IRQ_FLAG]) begin
            nvm_irq_flag <= 1'b0;
        end
    end

    // Registered outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= `NVMBA_RST_BYTE;
            irq_vector_req <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? read_mux : `NVMBA_RST_BYTE;
            irq_vector_req <= vector_cond && !irq_serviced; // R04
        end
    end

endmodule
